// File: src/clockgen_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the
//          clock generator watchdog and output-tuning control.
// Assumes: 50 MHz system clock; control bytes reached by byte index.
// Notes:   Definitions only; include by bare name.
`ifndef CLOCKGEN_CONSTS_SVH
`define CLOCKGEN_CONSTS_SVH

// Control byte indices
`define WD_CFG_OFS      8'h08
`define DRV_WD_OFS      8'h09
`define SKEW_OFS        8'h0A

// Time-out configuration byte fields
`define WD_TICK_BIT     0
`define WD_COUNT_LSB    1
`define WD_COUNT_MSB    5

// Drive and watchdog control byte fields
`define USB_DRV_BIT     7
`define PCI_CLOCK_DRIVE_HIGH_BIT     6
`define MID_DRV_BIT     5
`define RST_WD_BIT      4
`define RST_FC_BIT      3
`define EXPIRED_BIT     2
`define RUN_BIT         1

// Skew control byte fields
`define CPU_SKEW_MSB    7
`define CPU_SKEW_LSB    5
`define PCI_SKEW_MSB    3
`define PCI_SKEW_LSB    2
`define MID_SKEW_MSB    1
`define MID_SKEW_LSB    0

// Power-on defaults
`define WD_COUNT_RST    5'h1F
`define WD_TICK_RST     1'h0
`define DRV_WD_RST      8'h00
`define SKEW_RST        8'h00

// Timing
`define CLK_MHZ         50
`define SHORT_TICK_MS   150
`define LONG_TICK_MS    2500
`define SHORT_TICK_CYC  (`SHORT_TICK_MS * 1000 * `CLK_MHZ)
`define LONG_TICK_CYC   (`LONG_TICK_MS * 1000 * `CLK_MHZ)
`define RESET_PULSE_NS  320
`define RESET_PULSE_CYC ((`RESET_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define WD_FULL_UNITS   6'h20

`endif

// File: src/clockgen_pkg.sv
// Purpose: Shared types for the clock generator watchdog control.
// Assumes: Constants come from clockgen_consts.svh.
// Notes:   Types only.
package clockgen_pkg;

   // Byte-level control access
   typedef struct packed {
      logic       wrEn;    // Write strobe, one cycle
      logic       rdEn;    // Read strobe, one cycle
      logic [7:0] addr;    // Control byte index
      logic [7:0] wrData;  // Write data
   } ctl_req_s;

   // Decoded skew settings in picoseconds
   typedef struct packed {
      logic signed [10:0] cpuPs;        // CPU output skew
      logic signed [10:0] pciPs;        // PCI output skew
      logic signed [10:0] midPs;        // Mid-rate output skew
      logic               pciReserved;  // Reserved PCI code seen
   } skew_s;

   // Watchdog states
   typedef enum logic [1:0] {
      WD_STOPPED,
      WD_ARMED,
      WD_COUNTING,
      WD_RECOVERY
   } wd_state_e;

endpackage

// File: src/wd_tick_gen.sv
// Purpose: Tick-unit divider producing a one-cycle enable per watchdog unit.
// Assumes: Limits fit in 32 bits.
// Notes:   Restart realigns the unit so the first tick is a full unit.
`timescale 1ns/1ps
`include "clockgen_consts.svh"
module wd_tick_gen #(
   parameter int SHORT_CYC = `SHORT_TICK_CYC,
   parameter int LONG_CYC  = `LONG_TICK_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic nrst,
   // Control
   input  wire logic run,       // Count units while high
   input  wire logic restart,   // Realign unit boundary
   input  wire logic longUnit,  // 1 selects the long unit
   // Enable out
   output logic      tickPulse  // One cycle per elapsed unit
);

   logic [31:0] cnt_ff;  // Cycles into current unit
   logic [31:0] limit;   // Last cycle index of a unit

   // Unit length from tick select
   assign limit = longUnit ? 32'(LONG_CYC - 1) : 32'(SHORT_CYC - 1);

   // Unit counter and tick
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_ff    <= 32'h0;
         tickPulse <= 1'b0;
      end else if (!run || restart) begin
         cnt_ff    <= 32'h0;
         tickPulse <= 1'b0;
      end else if (cnt_ff >= limit) begin
         cnt_ff    <= 32'h0;
         tickPulse <= 1'b1;
      end else begin
         cnt_ff    <= cnt_ff + 32'h1;
         tickPulse <= 1'b0;
      end
   end

endmodule

// File: src/clockgen_watchdog_and_output_ctl.sv
// Purpose: Fail-safe watchdog, reset pulse generation, drive and skew
//          selection of the clock synthesizer control bytes.
// Assumes: Byte-level access already decoded from the serial control bus;
//          frequency change attempts arrive as one-cycle pulses.
// Notes:   Read data is registered, one cycle after the read strobe.
`timescale 1ns/1ps
`include "clockgen_consts.svh"
module clockgen_watchdog_and_output_ctl
   import clockgen_pkg::*;
#(
   parameter int SHORT_CYC = `SHORT_TICK_CYC,
   parameter int LONG_CYC  = `LONG_TICK_CYC,
   parameter int PULSE_CYC = `RESET_PULSE_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Control byte access
   input  wire ctl_req_s   ctrlReq,
   output logic [7:0]      rdData,
   output logic            rdValid,
   // Frequency change path
   input  wire logic       freqChangeReq,
   output logic            freqChangeAccept,
   // Recovery frequency source
   input  wire logic       recoverySourceSelect,
   input  wire logic [4:0] freqSelectStraps,
   output logic            recoveryLock,
   output logic            recoveryLoad,
   output logic            recoveryUseProgrammed,
   output logic [4:0]      recoveryStraps,
   // System reset request
   output logic            sysResetOut,
   // Output tuning
   output logic            usbClockDriveHigh,
   output logic            pciClockDriveHigh,
   output logic            midClockDriveHigh,
   output skew_s           skewSel
);

   // Control bits
   logic [4:0] watchdogTimeoutCount_ff;  // Programmed units
   logic       watchdogTickSelect_ff;    // 0 short, 1 long unit
   logic       resetOnExpiryEnable_ff;   // Pulse on expiry
   logic       resetOnFreqChangeEnable_ff; // Pulse on frequency change
   logic       watchdogRun_ff;           // Watchdog run bit
   logic       watchdogExpiredFlag_ff;   // Sticky time-out status
   logic       usbDrive_ff;              // 48/24 MHz drive
   logic       pciDrive_ff;              // PCI drive
   logic       midDrive_ff;              // Mid-rate drive
   logic [2:0] cpuSkewCode_ff;           // CPU skew code
   logic [1:0] pciSkewCode_ff;           // PCI skew code
   logic [1:0] midClockDelayCode_ff;     // Mid-rate skew code

   // Watchdog state
   wd_state_e  state_ff;                 // Current state
   wd_state_e  nxt_state;                // Next state
   logic [5:0] remain_ff;                // Units left
   logic [5:0] loadUnits;                // Reload value
   logic       tickPulse;                // One unit elapsed
   logic       expire;                   // Countdown done this cycle
   logic       freqAccepted;             // Change taken by the block

   // Reset pulse timing
   logic [15:0] pulseCnt_ff;             // Cycles of pulse left

   // Write strobes per byte
   logic wrCfg;
   logic wrDrv;
   logic wrSkew;

   // Byte decode
   assign wrCfg  = ctrlReq.wrEn && (ctrlReq.addr == `WD_CFG_OFS);
   assign wrDrv  = ctrlReq.wrEn && (ctrlReq.addr == `DRV_WD_OFS);
   assign wrSkew = ctrlReq.wrEn && (ctrlReq.addr == `SKEW_OFS);

   // Zero count stands for a full 32 units
   assign loadUnits = (watchdogTimeoutCount_ff == 5'h0) ? `WD_FULL_UNITS
                      : {1'b0, watchdogTimeoutCount_ff};

   // Frequency changes are refused while locked in recovery
   assign freqAccepted     = freqChangeReq && (state_ff != WD_RECOVERY);
   assign freqChangeAccept = freqAccepted;

   // Last unit elapsing ends the countdown
   assign expire = (state_ff == WD_COUNTING) && tickPulse
                   && (remain_ff == 6'h1);

   // CPU skew decode, signed picoseconds
   function automatic logic signed [10:0] cpuSkewPs(input logic [2:0] code);
      unique case (code)
         3'h0:    cpuSkewPs = 11'sh000;
         3'h1:    cpuSkewPs = -11'sh096;
         3'h2:    cpuSkewPs = -11'sh12C;
         3'h3:    cpuSkewPs = -11'sh1C2;
         3'h4:    cpuSkewPs = 11'sh096;
         3'h5:    cpuSkewPs = 11'sh12C;
         3'h6:    cpuSkewPs = 11'sh1C2;
         3'h7:    cpuSkewPs = 11'sh258;
      endcase
   endfunction

   // Two-bit skew decode; steps differ between PCI and mid-rate
   function automatic logic signed [10:0] pairSkewPs(input logic [1:0] code,
                                                     input logic       isPci);
      unique case (code)
         2'h0:    pairSkewPs = 11'sh000;
         2'h1:    pairSkewPs = isPci ? -11'sh1F4 : -11'sh096;
         2'h2:    pairSkewPs = isPci ? 11'sh000 : 11'sh096;
         2'h3:    pairSkewPs = isPci ? 11'sh1F4 : 11'sh12C;
      endcase
   endfunction

   // Unit divider, realigned whenever the countdown is (re)loaded
   wd_tick_gen #(
      .SHORT_CYC (SHORT_CYC),
      .LONG_CYC  (LONG_CYC)
   ) u_tick (
      .clk       (clk),
      .nrst      (nrst),
      .run       (state_ff == WD_COUNTING),
      .restart   (freqAccepted),
      .longUnit  (watchdogTickSelect_ff),
      .tickPulse (tickPulse)
   );

   // Time-out configuration byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdogTimeoutCount_ff <= `WD_COUNT_RST;
         watchdogTickSelect_ff   <= `WD_TICK_RST;
      end else if (wrCfg) begin
         watchdogTimeoutCount_ff <= ctrlReq.wrData[`WD_COUNT_MSB:`WD_COUNT_LSB];
         watchdogTickSelect_ff   <= ctrlReq.wrData[`WD_TICK_BIT];
      end
   end

   // Drive and watchdog control bits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         usbDrive_ff                <= 1'(`DRV_WD_RST >> `USB_DRV_BIT);
         pciDrive_ff                <= 1'b0;
         midDrive_ff                <= 1'b0;
         resetOnExpiryEnable_ff     <= 1'b0;
         resetOnFreqChangeEnable_ff <= 1'b0;
         watchdogRun_ff             <= 1'b0;
      end else if (wrDrv) begin
         usbDrive_ff                <= ctrlReq.wrData[`USB_DRV_BIT];
         pciDrive_ff                <= ctrlReq.wrData[`PCI_CLOCK_DRIVE_HIGH_BIT];
         midDrive_ff                <= ctrlReq.wrData[`MID_DRV_BIT];
         resetOnExpiryEnable_ff     <= ctrlReq.wrData[`RST_WD_BIT];
         resetOnFreqChangeEnable_ff <= ctrlReq.wrData[`RST_FC_BIT];
         watchdogRun_ff             <= ctrlReq.wrData[`RUN_BIT];
      end
   end

   // Sticky expired flag; a time-out wins over a same-cycle clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         watchdogExpiredFlag_ff <= 1'b0;
      end else if (expire) begin
         watchdogExpiredFlag_ff <= 1'b1;
      end else if (wrDrv && ctrlReq.wrData[`EXPIRED_BIT]) begin
         watchdogExpiredFlag_ff <= 1'b0;
      end
   end

   // Skew control byte
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cpuSkewCode_ff       <= 3'(`SKEW_RST >> `CPU_SKEW_LSB);
         pciSkewCode_ff       <= 2'h0;
         midClockDelayCode_ff <= 2'h0;
      end else if (wrSkew) begin
         cpuSkewCode_ff       <= ctrlReq.wrData[`CPU_SKEW_MSB:`CPU_SKEW_LSB];
         pciSkewCode_ff       <= ctrlReq.wrData[`PCI_SKEW_MSB:`PCI_SKEW_LSB];
         midClockDelayCode_ff <= ctrlReq.wrData[`MID_SKEW_MSB:`MID_SKEW_LSB];
      end
   end

   // Watchdog next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         // Stopped until software sets run
         WD_STOPPED: begin
            if (watchdogRun_ff) begin
               nxt_state = WD_ARMED;
            end
         end
         // Waiting for the first frequency change
         WD_ARMED: begin
            if (!watchdogRun_ff) begin
               nxt_state = WD_STOPPED;
            end else if (freqAccepted) begin
               nxt_state = WD_COUNTING;
            end
         end
         // Counting units down
         WD_COUNTING: begin
            if (!watchdogRun_ff) begin
               nxt_state = WD_STOPPED;
            end else if (expire) begin
               nxt_state = WD_RECOVERY;
            end
         end
         // Locked until the run bit is cleared
         WD_RECOVERY: begin
            if (!watchdogRun_ff) begin
               nxt_state = WD_STOPPED;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_ff <= WD_STOPPED;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Countdown of remaining units
   always_ff @(posedge clk) begin
      if (!nrst) begin
         remain_ff <= 6'h0;
      end else if (state_ff != WD_COUNTING || freqAccepted) begin
         remain_ff <= loadUnits;
      end else if (tickPulse) begin
         remain_ff <= remain_ff - 6'h1;
      end
   end

   // Recovery capture on time-out
   always_ff @(posedge clk) begin
      if (!nrst) begin
         recoveryLoad          <= 1'b0;
         recoveryUseProgrammed <= 1'b0;
         recoveryStraps        <= 5'h0;
      end else begin
         recoveryLoad <= expire;
         if (expire) begin
            recoveryUseProgrammed <= recoverySourceSelect;
            recoveryStraps        <= freqSelectStraps;
         end
      end
   end

   // Recovery lock level
   always_ff @(posedge clk) begin
      if (!nrst) begin
         recoveryLock <= 1'b0;
      end else begin
         recoveryLock <= (nxt_state == WD_RECOVERY);
      end
   end

   // Reset pulse of fixed width from either trigger
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pulseCnt_ff <= 16'h0;
         sysResetOut <= 1'b0;
      end else if ((expire && resetOnExpiryEnable_ff)
                   || (freqAccepted && resetOnFreqChangeEnable_ff)) begin
         pulseCnt_ff <= 16'(PULSE_CYC - 1);
         sysResetOut <= 1'b1;
      end else if (pulseCnt_ff != 16'h0) begin
         pulseCnt_ff <= pulseCnt_ff - 16'h1;
      end else begin
         sysResetOut <= 1'b0;
      end
   end

   // Drive and skew outputs
   always_ff @(posedge clk) begin
      if (!nrst) begin
         usbClockDriveHigh <= 1'b0;
         pciClockDriveHigh <= 1'b0;
         midClockDriveHigh <= 1'b0;
         skewSel           <= '0;
      end else begin
         usbClockDriveHigh   <= usbDrive_ff;
         pciClockDriveHigh   <= pciDrive_ff;
         midClockDriveHigh   <= midDrive_ff;
         skewSel.cpuPs       <= cpuSkewPs(cpuSkewCode_ff);
         skewSel.pciPs       <= pairSkewPs(pciSkewCode_ff, 1'b1);
         skewSel.pciReserved <= (pciSkewCode_ff == 2'h2);
         skewSel.midPs       <= pairSkewPs(midClockDelayCode_ff, 1'b0);
      end
   end

   // Registered read port; reserved bits and unknown bytes read zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdData  <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         rdValid <= ctrlReq.rdEn;
         if (ctrlReq.rdEn) begin
            unique case (ctrlReq.addr)
               // Time-out configuration
               `WD_CFG_OFS: rdData <= {2'h0, watchdogTimeoutCount_ff, watchdogTickSelect_ff};
               // Drive and watchdog control with live status
               `DRV_WD_OFS: rdData <= {usbDrive_ff, pciDrive_ff, midDrive_ff,
                                       resetOnExpiryEnable_ff, resetOnFreqChangeEnable_ff,
                                       watchdogExpiredFlag_ff, watchdogRun_ff, 1'b0};
               // Skew codes
               `SKEW_OFS:   rdData <= {cpuSkewCode_ff, 1'b0, pciSkewCode_ff,
                                       midClockDelayCode_ff};
               // Unmapped byte
               default:     rdData <= 8'h00;
            endcase
         end
      end
   end

endmodule

// File: dv/clockgen_ctl_chk.sv
// Purpose: Port-level assertions for the watchdog and output control.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every instance of the control block.
`timescale 1ns/1ps
module clockgen_ctl_chk
   import clockgen_pkg::*;
#(
   parameter int PULSE_CYC = 16
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Observed ports
   input wire ctl_req_s   ctrlReq,
   input wire logic       rdValid,
   input wire logic       freqChangeReq,
   input wire logic       freqChangeAccept,
   input wire logic       recoverySourceSelect,
   input wire logic [4:0] freqSelectStraps,
   input wire logic       recoveryLock,
   input wire logic       recoveryLoad,
   input wire logic       recoveryUseProgrammed,
   input wire logic [4:0] recoveryStraps,
   input wire logic       sysResetOut,
   input wire skew_s      skewSel
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   logic [7:0] hiCnt_ff; // Consecutive high cycles of the reset pulse

   // Measure reset pulse length
   always_ff @(posedge clk) begin
      if (!nrst || !sysResetOut) begin
         hiCnt_ff <= 8'h00;
      end else begin
         hiCnt_ff <= hiCnt_ff + 8'h01;
      end
   end

   // Expiry: load pulse with lock, then lock alone
   sequence s_load_once;
      recoveryLoad && recoveryLock ##1 !recoveryLoad && recoveryLock;
   endsequence

   property p_rd_answer;
      ctrlReq.rdEn |=> rdValid;
   endproperty
   property p_lock_load;
      $rose(recoveryLock) |-> s_load_once;
   endproperty
   property p_refuse;
      freqChangeReq && recoveryLock && !ctrlReq.wrEn && !$past(ctrlReq.wrEn)
         |-> !freqChangeAccept ##1 !$rose(sysResetOut);
   endproperty
   property p_accept;
      freqChangeReq && !recoveryLock && !$past(recoveryLock) |-> freqChangeAccept;
   endproperty
   property p_lock_hold;
      recoveryLock && !$past(ctrlReq.wrEn) |=> recoveryLock;
   endproperty
   property p_source;
      recoveryLoad |-> recoveryStraps == $past(freqSelectStraps)
         && recoveryUseProgrammed == $past(recoverySourceSelect);
   endproperty
   property p_pulse_cause;
      $rose(sysResetOut) |-> $past(freqChangeAccept) || recoveryLoad;
   endproperty
   property p_pulse_len;
      $fell(sysResetOut) |-> hiCnt_ff == PULSE_CYC;
   endproperty
   property p_pci_rsv;
      skewSel.pciReserved |-> skewSel.pciPs == 11'sd0;
   endproperty

   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   a_lock_load: assert property (p_lock_load) else $error("lock without load");
   a_refuse: assert property (p_refuse) else $error("change taken in recovery");
   a_accept: assert property (p_accept) else $error("change refused when free");
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early");
   a_source: assert property (p_source) else $error("recovery source wrong");
   a_pulse_cause: assert property (p_pulse_cause) else $error("pulse no cause");
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
   a_pci_rsv: assert property (p_pci_rsv) else $error("reserved code skew");
endmodule

bind clockgen_watchdog_and_output_ctl clockgen_ctl_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (
   .clk, .nrst, .ctrlReq, .rdValid, .freqChangeReq, .freqChangeAccept,
   .recoverySourceSelect, .freqSelectStraps, .recoveryLock, .recoveryLoad,
   .recoveryUseProgrammed, .recoveryStraps, .sysResetOut, .skewSel
);

// File: dv/smbus_host_model.sv
// Purpose: Host side of the control byte access.
// Assumes: Calls start right after a rising edge.
// Notes:   Released lines carry inverted values, not the last ones.
`timescale 1ns/1ps
module smbus_host_model
   import clockgen_pkg::*;
(
   // Clock
   input wire logic clk,
   // Byte access toward the block
   output ctl_req_s req
);
   // Idle at time zero
   initial begin
      req = '0;
   end

   // One strobed byte access, held for one sampling edge
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
      @(posedge clk);
      req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
   endtask
endmodule

// File: dv/tb.sv
// Purpose: Self-checking bench of the watchdog and output control.
// Assumes: Short and long units of 10 and 20 cycles, 4-cycle reset pulse.
// Notes:   Read results checked by a queue-driven monitor.
`timescale 1ns/1ps
`include "clockgen_consts.svh"
module tb
   import clockgen_pkg::*;
;
   localparam int SU = 10; // Short unit in cycles
   localparam int LU = 20; // Long unit in cycles
   localparam int PC = 4;  // Reset pulse length

   logic       clk, nrst, rdValid, freqChangeReq, freqChangeAccept;
   logic       recoverySourceSelect, recoveryLock, recoveryLoad, recoveryUseProgrammed;
   logic       sysResetOut, usbClockDriveHigh, pciClockDriveHigh, midClockDriveHigh;
   logic [4:0] freqSelectStraps, recoveryStraps;
   logic [7:0] rdData, v;
   ctl_req_s   ctrlReq;
   skew_s      skewSel;
   int         mismatches, numChecks;
   integer     seed;
   logic [7:0] expQ[$]; // Expected read bytes in order
   int cpuTab[8] = '{0, -150, -300, -450, 150, 300, 450, 600};
   int pciTab[4] = '{0, -500, 0, 500};
   int midTab[4] = '{0, -150, 150, 300};

   clockgen_watchdog_and_output_ctl #(.SHORT_CYC(SU), .LONG_CYC(LU), .PULSE_CYC(PC))
   i_clockgen_watchdog_and_output_ctl (
      .clk, .nrst, .ctrlReq, .rdData, .rdValid, .freqChangeReq, .freqChangeAccept,
      .recoverySourceSelect, .freqSelectStraps, .recoveryLock, .recoveryLoad,
      .recoveryUseProgrammed, .recoveryStraps, .sysResetOut, .usbClockDriveHigh,
      .pciClockDriveHigh, .midClockDriveHigh, .skewSel
   );
   smbus_host_model i_smbus_host_model (.clk, .req(ctrlReq));

   // Verdict and end of run
   task automatic final_report();
      if (mismatches == 0 && numChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // One comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Read with expectation noted
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      i_smbus_host_model.access(1'b0, a, 8'h00);
   endtask

   // Frequency change attempt, acceptance seen while held
   task automatic fc(input logic acc);
      @(posedge clk);
      freqChangeReq <= 1'b1;
      #1 chk("freqChangeAccept", 32'(acc), 32'(freqChangeAccept));
      @(posedge clk);
      freqChangeReq <= 1'b0;
   endtask

   // Bounded wait for lock, then expiry outputs
   task automatic expire(input int lo, input int hi, input logic rstOn);
      int k;
      k = 0;
      while (recoveryLock !== 1'b1 && k <= hi) begin
         @(posedge clk);
         k++;
      end
      chk("expiryCycles", 32'h1, 32'(k >= lo && k <= hi));
      if (k > hi) final_report();
      chk("sysResetOut", 32'(rstOn), 32'(sysResetOut));
      chk("recoveryStraps", 32'(freqSelectStraps), 32'(recoveryStraps));
      chk("recoveryUseProgrammed", 32'(recoverySourceSelect), 32'(recoveryUseProgrammed));
   endtask

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Read monitor, oldest expectation first
   always @(posedge clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) chk("readQueue", 32'h1, 32'h0);
         else chk("rdData", 32'(expQ.pop_front()), 32'(rdData));
      end
   end

   // Main sequence
   initial begin
      seed = 32'h6FF2;
      nrst <= 1'b0;
      freqChangeReq <= 1'b0;
      recoverySourceSelect <= 1'b0;
      freqSelectStraps <= 5'h00;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      // Power-on values and an unmapped byte
      rd(`WD_CFG_OFS, 8'h3E);
      rd(`DRV_WD_OFS, 8'h00);
      rd(`SKEW_OFS, 8'h00);
      rd(8'h07, 8'h00);
      v = 8'($random(seed));
      i_smbus_host_model.access(1'b1, `WD_CFG_OFS, v);
      rd(`WD_CFG_OFS, v & 8'h3F);
      // Every skew code, reserved bit randomised
      for (int i = 0; i < 8; i++) begin
         v = {i[2:0], 1'($random(seed)), i[1:0], ~i[1:0]};
         i_smbus_host_model.access(1'b1, `SKEW_OFS, v);
         rd(`SKEW_OFS, v & 8'hEF);
         chk("cpuPs", 32'(cpuTab[i]), 32'(skewSel.cpuPs));
         chk("pciPs", 32'(pciTab[i % 4]), 32'(skewSel.pciPs));
         chk("midPs", 32'(midTab[3 - i % 4]), 32'(skewSel.midPs));
         chk("pciReserved", 32'(i % 4 == 2), 32'(skewSel.pciReserved));
      end
      // Each drive bit alone, reserved bit set
      for (int j = 0; j < 3; j++) begin
         v = 8'h80 >> j;
         i_smbus_host_model.access(1'b1, `DRV_WD_OFS, v | 8'h01);
         rd(`DRV_WD_OFS, v);
         chk("usbDrive", 32'(j == 0), 32'(usbClockDriveHigh));
         chk("pciDrive", 32'(j == 1), 32'(pciClockDriveHigh));
         chk("midDrive", 32'(j == 2), 32'(midClockDriveHigh));
      end
      // Frequency-change reset off, then on; USB drive kept high
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h80);
      fc(1'b1);
      @(posedge clk);
      chk("sysResetOut", 32'h0, 32'(sysResetOut));
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h88);
      fc(1'b1);
      @(posedge clk);
      chk("sysResetOut", 32'h1, 32'(sysResetOut));
      repeat (PC) @(posedge clk);
      chk("sysResetOut", 32'h0, 32'(sysResetOut));
      // Short unit, count 2, reset on expiry
      freqSelectStraps <= 5'($random(seed));
      recoverySourceSelect <= 1'($random(seed));
      i_smbus_host_model.access(1'b1, `WD_CFG_OFS, 8'h04);
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h12);
      repeat (3 * SU) @(posedge clk);
      chk("recoveryLock", 32'h0, 32'(recoveryLock));
      fc(1'b1);
      expire(2 * SU, 2 * SU + 4, 1'b1);
      rd(`DRV_WD_OFS, 8'h16);
      fc(1'b0);
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h02);
      rd(`DRV_WD_OFS, 8'h06);
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h06);
      rd(`DRV_WD_OFS, 8'h02);
      chk("recoveryLock", 32'h1, 32'(recoveryLock));
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h00);
      repeat (2) @(posedge clk);
      chk("recoveryLock", 32'h0, 32'(recoveryLock));
      // Long unit, count 0, stop midway then restart
      freqSelectStraps <= ~freqSelectStraps;
      recoverySourceSelect <= ~recoverySourceSelect;
      i_smbus_host_model.access(1'b1, `WD_CFG_OFS, 8'h01);
      // Captured recovery source must not follow the live inputs
      chk("strapsHeld", 32'(5'(~freqSelectStraps)), 32'(recoveryStraps));
      chk("srcHeld", 32'(!recoverySourceSelect), 32'(recoveryUseProgrammed));
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h02);
      fc(1'b1);
      repeat (20 * LU) @(posedge clk);
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h00);
      i_smbus_host_model.access(1'b1, `DRV_WD_OFS, 8'h02);
      repeat (35 * LU) @(posedge clk);
      chk("recoveryLock", 32'h0, 32'(recoveryLock));
      fc(1'b1);
      expire(32 * LU, 32 * LU + 4, 1'b0);
      // Second reset while locked
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(`DRV_WD_OFS, 8'h00);
      chk("recoveryLock", 32'h0, 32'(recoveryLock));
      repeat (3) @(posedge clk);
      chk("readQueueEmpty", 32'h0, 32'(expQ.size()));
      final_report();
   end
endmodule
